// >>> src/tms_pkg.sv
`default_nettype none
package tms_pkg;
  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int AXES         = 30;          // Axes on the motion network
  localparam int AXW          = 5;
  localparam int PROCS        = 15;
  localparam int HI_FIRST     = 13;          // Slots 13..14 are high class
  localparam int CLK_NS       = 25;
  localparam int CYCLE_BASE_US = 1000;       // Shortest operating cycle
  localparam int CYCLE_BASE_CLKS = CYCLE_BASE_US * 1000 / CLK_NS;
  // Update interval in seconds as Q0.32, indexed by interval select
  localparam logic [31:0] DT_0P5 = 32'h0020C49C;
  localparam logic [31:0] DT_1   = 32'h00418937;
  localparam logic [31:0] DT_2   = 32'h0083126F;
  localparam logic [31:0] DT_4   = 32'h010624DD;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] R_CTRL   = 8'h00;   // [1:0] interval select
  localparam logic [7:0] R_PROCEN = 8'h04;   // [14:0] process slot enable
  localparam logic [7:0] R_STATUS = 8'h08;   // slice, busy, last process
  localparam logic [7:0] R_AXSEL  = 8'h0C;
  localparam logic [7:0] R_ARG    = 8'h10;
  localparam logic [7:0] R_CMD    = 8'h14;
  localparam logic [7:0] R_RATEA  = 8'h18;
  localparam logic [7:0] R_RATEB  = 8'h1C;
  localparam logic [7:0] R_SPEED  = 8'h20;
  localparam logic [7:0] R_SCALE  = 8'h24;
  localparam logic [7:0] R_POS    = 8'h28;   // Demand position, units
  localparam logic [7:0] R_FBPOS  = 8'h2C;   // Absolute feedback, counts
  localparam logic [7:0] R_AXCFG  = 8'h30;   // [0] encoder src [1] inverter
  localparam logic [7:0] R_AXSTAT = 8'h34;   // [1:0] mode [2] reverse
  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  SEL_0P5   = 2'h0;
  localparam logic [1:0]  SEL_1     = 2'h1;
  localparam logic [1:0]  SEL_2     = 2'h2;
  localparam logic [1:0]  SEL_4     = 2'h3;
  localparam logic [1:0]  CTRL_RST  = SEL_1;
  localparam logic [31:0] SCALE_RST = 32'h00000001;
  localparam logic [3:0] C_REL    = 4'h1;
  localparam logic [3:0] C_ABS    = 4'h2;
  localparam logic [3:0] C_FWD    = 4'h3;
  localparam logic [3:0] C_REV    = 4'h4;
  localparam logic [3:0] C_CANCEL = 4'h5;
  localparam logic [3:0] C_ALL    = 4'h6;
  localparam logic [3:0] C_REDEF  = 4'h7;

  typedef enum logic [1:0] {
    TMS_IDLE = 2'b00,
    TMS_PTP  = 2'b01,
    TMS_CONT = 2'b10,
    TMS_STOP = 2'b11
  } tms_mode_t;

  typedef struct packed {
    tms_mode_t   mode;
    logic        rev;         // Direction of travel
    logic        enc_src;     // Feedback from external encoder
    logic        inverter;    // Node is an inverter
    logic [31:0] rate_a;      // units/s^2
    logic [31:0] rate_b;      // units/s^2
    logic [31:0] speed;       // units/s
    logic [31:0] scale;       // counts per unit
    logic [63:0] pos;         // Q32.32 units, signed
    logic [31:0] vel;         // Q16.16 units/s magnitude
    logic [31:0] target;      // units, signed
    logic [31:0] fb_off;      // counts
  } tms_axis_t;

  typedef struct packed {
    logic [AXW-1:0] axis;
    logic [31:0]    counts;
    logic           inverter;
    logic           stb;
  } tms_demand_t;

  typedef struct packed {
    logic [3:0] id;
    logic       stb;
    logic [1:0] slice;
  } tms_proc_t;
endpackage : tms_pkg
`default_nettype wire

// >>> src/tms_top.sv
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tms_top #(
  parameter int CYCLE_CLKS = tms_pkg::CYCLE_BASE_CLKS
) (
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  output logic      [4:0]         fb_axis,
  input  wire logic [31:0]        fb_drive_pos,
  input  wire logic [31:0]        fb_enc_pos,
  output tms_pkg::tms_demand_t    demand,
  output tms_pkg::tms_proc_t      proc_run,
  output logic                    led_stb,
  output logic                    comm_stb
);
  import tms_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       isel;
    logic [14:0]      proc_en;
    logic [14:0]      done_lo;
    logic [14:0]      done_hi;
    logic [AXW-1:0]   axsel;
    logic [31:0]      arg;
    logic [31:0]      cnt;
    logic [1:0]       slice;
    logic             busy;
    logic             lo_pend;
    logic [AXW-1:0]   idx;
    logic             ack;
    logic [31:0]      rdata;
    tms_demand_t      dem;
    tms_proc_t        prc;
    logic             led;
    logic             comm;
    tms_axis_t [AXES-1:0] ax;
  } tms_state_t;

  tms_state_t s;
  tms_state_t next_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Highest enabled slot not yet served; wraps when class exhausted
  function automatic logic [4:0] pick(input logic [14:0] cand);
    logic [4:0] r;
    r = 5'h1F;
    for (int i = 0; i < PROCS; i++) begin
      if (cand[i]) r = 5'(i);
    end
    return r;
  endfunction

  // One profile step for one axis
  function automatic tms_axis_t step(input tms_axis_t a,
                                     input logic [31:0] dt);
    tms_axis_t   o;
    logic [63:0] tgt, rem, dv_a, dv_b, v2, brk, dp;
    logic [31:0] vmax;
    logic        brake;
    o    = a;
    tgt  = {a.target, 32'h0};
    rem  = a.rev ? (a.pos - tgt) : (tgt - a.pos);
    dv_a = (64'(a.rate_a) * 64'(dt)) >> 16;
    dv_b = (64'(a.rate_b) * 64'(dt)) >> 16;
    v2   = 64'(a.vel) * 64'(a.vel);
    brk  = 64'(a.rate_b) * 64'(rem[63:32]) << 1;
    vmax = {a.speed[15:0], 16'h0};
    // Stop ramping up once v^2 >= 2*d*remaining, giving a triangle
    brake = (a.mode == TMS_PTP) && ({32'h0, v2[63:32]} >= brk);
    if (a.mode == TMS_STOP || brake) begin
      o.vel = (64'(a.vel) > dv_b) ? a.vel - dv_b[31:0] : 32'h0;
    end else if (a.mode != TMS_IDLE) begin
      // Ramp up to demand speed, then cruise
      o.vel = (64'(a.vel) + dv_a >= 64'(vmax)) ? vmax
              : a.vel + dv_a[31:0];
    end else begin
      o.vel = 32'h0;
    end
    dp = (64'(o.vel) * 64'(dt)) >> 16;
    if (a.mode == TMS_PTP && (dp >= rem || rem[63]  // Or stalled just short
                              || (brake && o.vel == 32'h0))) begin
      o.pos  = tgt;
      o.vel  = 32'h0;
      o.mode = TMS_IDLE;
    end else begin
      o.pos = a.rev ? a.pos - dp : a.pos + dp;
      if (a.mode == TMS_STOP && o.vel == 32'h0) o.mode = TMS_IDLE;
    end
    return o;
  endfunction

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        req, axis_wr, fb_rd;
  logic [31:0] cyc_len, slice_len, dt, fb_raw;
  logic [63:0] redef_cnt;

  assign req     = avs_read | avs_write;
  // Axis state must not change under the running sequence
  assign axis_wr = avs_write && avs_address >= R_CMD
                   && avs_address <= R_SCALE || avs_write
                   && avs_address == R_AXCFG;
  assign avs_waitrequest = req & ~s.ack;
  assign fb_rd   = avs_read && avs_address == R_FBPOS; // Mux follows pass
  assign fb_raw  = s.ax[fb_axis].enc_src ? fb_enc_pos : fb_drive_pos;
  assign fb_axis = s.busy ? s.idx : s.axsel;
  assign redef_cnt = 64'(s.arg) * 64'(s.ax[s.axsel].scale);

  // Operating cycle and update interval per select
  always_comb begin
    case (s.isel)
      SEL_0P5: dt = DT_0P5;
      SEL_1:   dt = DT_1;
      SEL_2:   dt = DT_2;
      default: dt = DT_4;
    endcase
    // Half-ms interval keeps the 1 ms cycle and runs motion twice in it
    cyc_len = (s.isel == SEL_0P5) ? 32'(CYCLE_CLKS)
              : 32'(CYCLE_CLKS) << (s.isel - 2'h1);
    slice_len = cyc_len >> 2;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [4:0]  p;
    logic [14:0] lo_mask, hi_mask;
    logic [31:0] fbv;
    logic [63:0] dc;
    p       = 5'h1F;
    lo_mask = 15'h1FFF;
    hi_mask = 15'h6000;
    fbv     = 32'h0;
    dc      = 64'h0;
    next_s  = s;
    next_s.ack      = 1'b0;
    next_s.dem.stb  = 1'b0;
    next_s.prc.stb  = 1'b0;
    next_s.led      = 1'b0;
    next_s.comm     = 1'b0;

    // Slice timer
    if (s.cnt + 32'h1 >= slice_len) begin
      next_s.cnt   = 32'h0;
      next_s.slice = s.slice + 2'h1;
    end else begin
      next_s.cnt = s.cnt + 32'h1;
    end

    // Work at the start of each slice
    if (s.cnt == 32'h0) begin
      case (s.slice)
        2'h0: begin
          next_s.busy    = 1'b1;
          next_s.idx     = '0;
          next_s.lo_pend = 1'b1;
        end
        2'h1: begin
          next_s.lo_pend = 1'b0;
          p = pick(s.proc_en & hi_mask & ~s.done_hi);
          if (p == 5'h1F) begin
            next_s.done_hi = 15'h0;
            p = pick(s.proc_en & hi_mask);
          end
        end
        2'h2: begin
          if (s.isel == SEL_0P5) begin
            next_s.busy = 1'b1;
            next_s.idx  = '0;
          end
          next_s.led = 1'b1;
          p = pick(s.proc_en & hi_mask & ~(s.done_hi | 15'(p)));
          if (p == 5'h1F) begin
            next_s.done_hi = 15'h0;
            p = pick(s.proc_en & hi_mask);
          end
        end
        default: begin
          next_s.comm = 1'b1;
        end
      endcase
    end

    // Low class runs once the slice-one motion pass has finished
    if (s.lo_pend && !s.busy && s.cnt != 32'h0) begin
      next_s.lo_pend = 1'b0;
      p = pick(s.proc_en & lo_mask & ~s.done_lo);
      if (p == 5'h1F) begin
        next_s.done_lo = 15'h0;
        p = pick(s.proc_en & lo_mask);
      end
    end
    if (p != 5'h1F) begin
      next_s.prc.id  = p[3:0];
      next_s.prc.stb = 1'b1;
      if (p >= 5'(HI_FIRST)) begin
        next_s.done_hi = next_s.done_hi | (15'h1 << p);
      end else begin
        next_s.done_lo = next_s.done_lo | (15'h1 << p);
      end
    end
    next_s.prc.slice = s.slice;

    // Motion sequence: one axis per clock, all node kinds alike
    if (s.busy) begin
      next_s.ax[s.idx] = step(s.ax[s.idx], dt);
      dc = 64'(next_s.ax[s.idx].pos[63:32]) * 64'(s.ax[s.idx].scale);
      next_s.dem.axis     = s.idx;
      next_s.dem.counts   = dc[31:0];
      next_s.dem.inverter = s.ax[s.idx].inverter;
      next_s.dem.stb      = 1'b1;
      if (s.idx == AXW'(AXES - 1)) begin
        next_s.busy = 1'b0;
      end else begin
        next_s.idx = s.idx + AXW'(1);
      end
    end

    // Bus access: answer one cycle after the request is seen; axis writes and feedback reads wait until the pass ends
    if (req && !s.ack && !((axis_wr || fb_rd) && s.busy)) begin
      next_s.ack = 1'b1;
      fbv = fb_raw - s.ax[s.axsel].fb_off;
      case (avs_address)
        R_CTRL:   next_s.rdata = {30'h0, s.isel};
        R_PROCEN: next_s.rdata = {17'h0, s.proc_en};
        R_STATUS: next_s.rdata = {24'h0, s.prc.id, s.busy, 1'b0, s.slice};
        R_AXSEL:  next_s.rdata = {27'h0, s.axsel};
        R_ARG:    next_s.rdata = s.arg;
        R_RATEA:  next_s.rdata = s.ax[s.axsel].rate_a;
        R_RATEB:  next_s.rdata = s.ax[s.axsel].rate_b;
        R_SPEED:  next_s.rdata = s.ax[s.axsel].speed;
        R_SCALE:  next_s.rdata = s.ax[s.axsel].scale;
        R_POS:    next_s.rdata = s.ax[s.axsel].pos[63:32];
        R_FBPOS:  next_s.rdata = fbv;
        R_AXCFG:  next_s.rdata = {30'h0, s.ax[s.axsel].inverter,
                                  s.ax[s.axsel].enc_src};
        R_AXSTAT: next_s.rdata = {29'h0, s.ax[s.axsel].rev,
                                  s.ax[s.axsel].mode};
        default:  next_s.rdata = 32'h0;
      endcase
      if (avs_write) begin
        next_s.rdata = 32'h0;
        case (avs_address)
          R_CTRL:   next_s.isel    = avs_writedata[1:0];
          R_PROCEN: next_s.proc_en = avs_writedata[14:0];
          R_AXSEL: begin
            if (avs_writedata[4:0] < 5'(AXES)) begin
              next_s.axsel = avs_writedata[4:0];
            end
          end
          R_ARG:    next_s.arg = avs_writedata;
          R_RATEA:  next_s.ax[s.axsel].rate_a = avs_writedata;
          R_RATEB:  next_s.ax[s.axsel].rate_b = avs_writedata;
          R_SPEED:  next_s.ax[s.axsel].speed  = avs_writedata;
          R_SCALE:  next_s.ax[s.axsel].scale  = avs_writedata;
          R_AXCFG: begin
            next_s.ax[s.axsel].enc_src  = avs_writedata[0];
            next_s.ax[s.axsel].inverter = avs_writedata[1];
          end
          R_CMD: begin
            case (avs_writedata[3:0])
              C_REL, C_ABS: begin
                next_s.ax[s.axsel].target =
                  (avs_writedata[3:0] == C_ABS) ? s.arg
                  : s.ax[s.axsel].pos[63:32] + s.arg;
                next_s.ax[s.axsel].rev = $signed(next_s.ax[s.axsel].target)
                  < $signed(s.ax[s.axsel].pos[63:32]);
                next_s.ax[s.axsel].mode = TMS_PTP;
              end
              C_FWD, C_REV: begin
                next_s.ax[s.axsel].rev  = (avs_writedata[3:0] == C_REV);
                next_s.ax[s.axsel].mode = TMS_CONT;
              end
              C_CANCEL: begin
                if (s.ax[s.axsel].mode != TMS_IDLE) begin
                  next_s.ax[s.axsel].mode = TMS_STOP;
                end
              end
              C_ALL: begin
                for (int i = 0; i < AXES; i++) begin
                  if (s.ax[i].mode != TMS_IDLE) begin
                    next_s.ax[i].mode = TMS_STOP;
                  end
                end
              end
              C_REDEF: begin
                if (s.ax[s.axsel].mode == TMS_IDLE) begin
                  next_s.ax[s.axsel].pos    = {s.arg, 32'h0};
                  next_s.ax[s.axsel].target = s.arg;
                  next_s.ax[s.axsel].fb_off = fb_raw - redef_cnt[31:0];
                end
              end
              default: ;
            endcase
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      s       <= '0;
      s.isel  <= CTRL_RST;
      for (int i = 0; i < AXES; i++) s.ax[i].scale <= SCALE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign avs_readdata = s.rdata;
  assign demand       = s.dem;
  assign proc_run     = s.prc;
  assign led_stb      = s.led;
  assign comm_stb     = s.comm;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence seq_start;
    s.slice == 2'h0 && s.cnt == 32'h0;
  endsequence
  sequence seq_pass;
    s.busy [*8];
  endsequence

  a_seq_starts: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_start |=> seq_pass)
    else $error("motion pass did not start in slice one");
  a_pass_length: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(s.busy) |-> ##29 (s.idx == 5'h1D) ##1 !s.busy)
    else $error("motion pass did not cover thirty axes");
  a_half_ms_run: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s.slice == 2'h2 && s.cnt == 32'h0) |=>
      (s.busy == ($past(s.isel) == SEL_0P5)))
    else $error("third slice motion run wrong for interval");
  a_comm_slice: assert property (@(posedge sys_clk) disable iff (!rstn)
    comm_stb |-> $past(s.slice) == 2'h3)
    else $error("communication strobe outside fourth slice");
  a_led_slice: assert property (@(posedge sys_clk) disable iff (!rstn)
    led_stb |-> $past(s.slice) == 2'h2)
    else $error("indicator strobe outside third slice");
  a_high_class: assert property (@(posedge sys_clk) disable iff (!rstn)
    (proc_run.stb && proc_run.slice != 2'h0) |->
      proc_run.id >= 4'hD)
    else $error("low class process in high slice");
  a_slice_equal: assert property (@(posedge sys_clk) disable iff (!rstn)
    ($changed(s.slice) && s.isel == $past(s.isel, 2)) |->
      $past(s.cnt) == slice_len - 32'h1)
    else $error("slice length differs from a quarter cycle");
  a_demand_each: assert property (@(posedge sys_clk) disable iff (!rstn)
    s.busy |=> demand.stb && demand.axis == $past(s.idx))
    else $error("demand strobe missing for an axis");
  a_stop_ramps: assert property (@(posedge sys_clk) disable iff (!rstn)
    (s.busy && s.ax[s.idx].mode == TMS_STOP) |=>
      $past(s.ax[s.idx].vel) >= s.ax[$past(s.idx)].vel)
    else $error("cancelled axis speed rose");
endmodule : tms_top
`default_nettype wire

// >>> testbench/tms_drive_model.sv
`timescale 1ns/1ps
`default_nettype none
module tms_drive_model (
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire logic [4:0]           fb_axis,
  input  wire tms_pkg::tms_demand_t demand,
  output logic      [31:0]          fb_drive_pos,
  output logic      [31:0]          fb_enc_pos,
  output logic      [31:0]          last_cnt [30],
  output logic      [29:0]          last_inv,
  output logic                      seq_bad
);
  import tms_pkg::*;
  logic [4:0] exp_ax;

  // Feedback differs per axis and per source so a wrong pick shows
  assign fb_drive_pos = 32'h00001000 + {27'h0, fb_axis};
  assign fb_enc_pos   = 32'h00020000 - {27'h0, fb_axis};

  // Latch each node's demand; axes must come 0..29 in turn
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      exp_ax  <= 5'h0;
      seq_bad <= 1'b0;
    end else if (demand.stb) begin
      if (demand.axis != exp_ax) seq_bad <= 1'b1;
      exp_ax <= (demand.axis == 5'h1D) ? 5'h0 : demand.axis + 5'h1;
      last_cnt[demand.axis] <= demand.counts;
      last_inv[demand.axis] <= demand.inverter;
    end
  end
endmodule // tms_drive_model
`default_nettype wire

// >>> testbench/trapezoid_motion_scheduler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module trapezoid_motion_scheduler_tb;
  import tms_pkg::*;
  localparam int C = 200;  // Short cycle keeps the run brief
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  avs_address = 8'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, fb_drive_pos, fb_enc_pos, q;
  logic        avs_waitrequest, led_stb, comm_stb, seq_bad;
  logic [4:0]  fb_axis;
  logic [31:0] last_cnt [30];
  logic [29:0] last_inv;
  logic [3:0]  hi_last = 4'h0;
  logic [3:0]  lo_last = 4'h0;
  tms_demand_t demand;
  tms_proc_t   proc_run;
  int cyc = 0, t_pass = 0, dt_pass = 0, t_led = 0, dt_lc = 0;
  int n_pass = 0, n_wait = 0, fail_count = 0, n_tests = 0;

  always #12.5 sys_clk = ~sys_clk;

  tms_top #(.CYCLE_CLKS(C)) u_tms_top (
    .sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .fb_axis(fb_axis),
    .fb_drive_pos(fb_drive_pos), .fb_enc_pos(fb_enc_pos),
    .demand(demand), .proc_run(proc_run), .led_stb(led_stb),
    .comm_stb(comm_stb));

  tms_drive_model u_tms_drive_model (
    .sys_clk(sys_clk), .rstn(rstn), .fb_axis(fb_axis), .demand(demand),
    .fb_drive_pos(fb_drive_pos), .fb_enc_pos(fb_enc_pos),
    .last_cnt(last_cnt), .last_inv(last_inv), .seq_bad(seq_bad));

  task check(input logic [31:0] seen, input logic [31:0] exp,
             input string m);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Timing monitor, timeout and process scheduling watch
  always @(posedge sys_clk) begin
    if (cyc == 90000) begin
      fail_count++;
      test_done();
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (demand.stb && demand.axis == 5'h0) begin
      dt_pass <= cyc - t_pass;
      t_pass  <= cyc;
      n_pass  <= n_pass + 1;
    end
    if (led_stb) t_led <= cyc;
    if (comm_stb) dt_lc <= cyc - t_led;
    if (proc_run.stb && proc_run.id >= 4'hD) begin
      check(proc_run.slice inside {2'h1, 2'h2}, 1, "high slice");
      check(proc_run.id, hi_last == 4'hE ? 4'hD : 4'hE, "high id");
      hi_last <= proc_run.id;
    end else if (proc_run.stb) begin
      check(proc_run.slice, 2'h0, "low slice");
      check(proc_run.id, lo_last == 4'h5 ? 4'h3 : 4'h5, "low id");
      lo_last <= proc_run.id;
    end
  end

  // Avalon access: hold until waitrequest is seen low at an edge
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= we;
    avs_read      <= !we;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task wait_pass(input int n);
    int s;
    s = n_pass;
    while (n_pass < s + n) @(posedge sys_clk);
  endtask

  // Poll once per pass until the selected axis is idle
  task wait_idle;
    for (n_wait = 0; n_wait < 400; n_wait++) begin
      wait_pass(1);
      bus(0, R_AXSTAT, 0);
      if (q[1:0] === 2'h0) break;
    end
  endtask

  task ax_cfg(input logic [31:0] a);
    bus(1, R_AXSEL, a);
    bus(1, R_SPEED, 32'h3E8);
    bus(1, R_RATEA, 32'h186A0);
    bus(1, R_RATEB, 32'h186A0);
  endtask

  task t_reset;
    bus(0, R_CTRL, 0);
    check(q, CTRL_RST, "ctrl reset");
    bus(1, R_AXSEL, 32'h7);
    bus(0, R_SCALE, 0);
    check(q, SCALE_RST, "scale reset");
    bus(1, R_AXSEL, 32'h1E);
    bus(0, R_AXSEL, 0);
    check(q, 32'h7, "axis range");
    bus(1, 8'h3C, 32'hFFFF);
    bus(0, 8'h3C, 0);
    check(q, 32'h0, "unmapped read");
    bus(1, R_PROCEN, 32'h6028);
    bus(1, R_AXSEL, 32'h4);
    bus(1, R_AXCFG, 32'h3);
    bus(0, R_FBPOS, 0);
    check(q, 32'h1FFFC, "encoder feedback");
    wait_pass(2);
    check(last_inv[4], 1'b1, "inverter node");
    check(last_inv[5], 1'b0, "servo node");
  endtask

  // Pass spacing and slice length for every interval select
  task t_interval;
    int cl;
    for (int s = 0; s < 4; s++) begin
      cl = (s == 0) ? C : C << (s - 1);
      bus(1, R_CTRL, s);
      bus(0, R_CTRL, 0);
      check(q, s, "interval select");
      wait_pass(3);
      check(dt_pass, s == 0 ? C / 2 : cl, "pass gap");
      check(dt_lc, cl / 4, "slice length");
    end
    bus(1, R_CTRL, SEL_1);
  endtask

  task t_move;
    ax_cfg(1);
    bus(1, R_SCALE, 32'h3);
    bus(0, R_SPEED, 0);
    check(q, 32'h3E8, "speed readback");
    bus(1, R_ARG, 32'h64);
    bus(1, R_CMD, C_REDEF);
    bus(0, R_POS, 0);
    check(q, 32'h64, "redefined pos");
    bus(0, R_FBPOS, 0);
    check(q, 32'h12C, "feedback abs");
    bus(1, R_ARG, 32'h5);
    bus(1, R_CMD, C_REL);
    wait_idle;
    bus(0, R_POS, 0);
    check(q, 32'h69, "relative end");
    wait_pass(2);
    check(last_cnt[1], 32'h13B, "counts");
    bus(1, R_ARG, 32'h5A);
    bus(1, R_CMD, C_ABS);
    wait_pass(4);
    bus(0, R_AXSTAT, 0);
    check(q[2:0], 3'h5, "ptp reverse");
    wait_idle;
    bus(0, R_POS, 0);
    check(q, 32'h5A, "absolute end");
  endtask

  // Continuous moves, one-axis cancel, then abort of all axes
  task t_cancel;
    ax_cfg(2);
    bus(1, R_CMD, C_FWD);
    ax_cfg(3);
    bus(1, R_CMD, C_REV);
    wait_pass(15);
    bus(0, R_AXSTAT, 0);
    check(q[2:0], 3'h6, "reverse cont");
    bus(1, R_AXSEL, 32'h2);
    bus(0, R_AXSTAT, 0);
    check(q[2:0], 3'h2, "forward cont");
    bus(1, R_CMD, C_CANCEL);
    wait_pass(1);
    bus(0, R_AXSTAT, 0);
    check(q[1:0], TMS_STOP, "cancel ramp");
    bus(1, R_AXSEL, 32'h3);
    bus(0, R_AXSTAT, 0);
    check(q[1:0], TMS_CONT, "other axis");
    bus(1, R_CMD, C_ALL);
    wait_pass(1);
    bus(0, R_AXSTAT, 0);
    check(q[1:0], TMS_STOP, "abort ramp");
    wait_idle;
    check(n_wait inside {[6:12]}, 1, "ramp time");
    check(seq_bad, 1'b0, "axis order");
  endtask

  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset;
    t_interval;
    t_move;
    t_cancel;
    test_done;
  end
endmodule // trapezoid_motion_scheduler_tb
`default_nettype wire
